// File: lpfc_freeze_ctrl.sv
`timescale 1ns/1ps
module lpfc_freeze_ctrl
   import lpfc_pkg::*;
(
   input  wire logic         CLOCK_IN,
   input  wire logic         SYS_RST_IN,
   input  wire lpfc_supply_t SUPPLY_IN,
   input  wire logic         FREEZE_REQUEST_PIN_IN,
   input  wire logic         TYPE2_IN,
   input  wire logic         DONE_HOUSE_IN,
   input  wire logic         PLL_RUNNING_IN,
   output logic              IO_OE_N_OUT,
   output logic              INPUT_TIE_OUT,
   output logic              PLL_OFF_OUT,
   output logic              CLK_GATE_N_OUT,
   output logic              WAIT_HOUSE_OUT,
   output logic              FREEZE_PERMIT_OUT,
   output logic              FROZEN_OUT,
   output logic              CTX_LOST_OUT,
   output logic              SELF_RESET_OUT
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [1:0]   pin_sync;
   logic [1:0]   core_sync;
   logic [1:0]   io_sync;
   logic [1:0]   type_sync;
   logic [1:0]   pll_sync;
   logic         pin;
   logic         supplies_ok;
   lpfc_state_t  state;
   lpfc_state_t  next_state;
   logic [3:0]   cnt;
   logic [3:0]   out_cnt;
   logic         core_prev;

   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         pin_sync  <= 2'h0;
         core_sync <= 2'h0;
         io_sync   <= 2'h0;
         type_sync <= 2'h0;
         pll_sync  <= 2'h0;
      end else begin
         pin_sync  <= {pin_sync[0], FREEZE_REQUEST_PIN_IN};
         core_sync <= {core_sync[0], SUPPLY_IN.core_ok};
         io_sync   <= {io_sync[0], SUPPLY_IN.io_ok};
         type_sync <= {type_sync[0], TYPE2_IN};
         pll_sync  <= {pll_sync[0], PLL_RUNNING_IN};
      end
   end

   assign pin = pin_sync[1];
   assign supplies_ok = core_sync[1] & io_sync[1];

   ////////////////////////////////////////////////////////////////////////////
   // Management state machine
   always_comb begin
      next_state = state;
      case (state)
         LPFC_RUN: begin
            if (pin) begin
               next_state = LPFC_CONFIRM;
            end
         end
         LPFC_CONFIRM: begin
            if (!pin) begin
               next_state = LPFC_RUN;
            end else if (cnt == CNT_ONE) begin
               next_state = (type_sync[1] == LPFC_TYPE2) ? LPFC_HOUSE : LPFC_GATE;
            end
         end
         LPFC_HOUSE: begin
            if (!pin) begin
               next_state = LPFC_RELEASE;
            end else if (DONE_HOUSE_IN) begin
               next_state = LPFC_GATE;
            end
         end
         LPFC_GATE: begin
            next_state = pin ? LPFC_PERMIT : LPFC_RELEASE;
         end
         // freeze only with permit and pin
         LPFC_PERMIT: begin
            next_state = pin ? LPFC_FROZEN : LPFC_RELEASE;
         end
         LPFC_FROZEN: begin
            if (!pin) begin
               next_state = LPFC_RELEASE;
            end
         end
         LPFC_RELEASE: begin
            if (pll_sync[1] && cnt == CNT_ONE) begin
               next_state = LPFC_RUN;
            end
         end
         default: begin
            next_state = LPFC_RUN;
         end
      endcase
   end

   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN || !supplies_ok) begin
         state <= LPFC_RUN;
      end else begin
         state <= next_state;
      end
   end

   // Interval counter for confirm and release
   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN || state != next_state) begin
         cnt <= (next_state == LPFC_CONFIRM) ? 4'(PERSIST_CYC) : 4'(PLL_LOCK_CYC);
      end else if (cnt != CNT_ZERO && (state != LPFC_RELEASE || pll_sync[1])) begin
         cnt <= cnt - CNT_ONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         WAIT_HOUSE_OUT    <= 1'b0;
         CLK_GATE_N_OUT    <= 1'b1;
         FREEZE_PERMIT_OUT <= 1'b0;
         FROZEN_OUT        <= 1'b0;
         INPUT_TIE_OUT     <= 1'b0;
         PLL_OFF_OUT       <= 1'b0;
         SELF_RESET_OUT    <= 1'b0;
      end else begin
         WAIT_HOUSE_OUT    <= (next_state == LPFC_HOUSE);
         // gate held through entry and exit
         CLK_GATE_N_OUT    <= !(next_state inside {LPFC_GATE, LPFC_PERMIT, LPFC_FROZEN,
                                                   LPFC_RELEASE});
         FREEZE_PERMIT_OUT <= (next_state inside {LPFC_PERMIT, LPFC_FROZEN}) & pin;
         FROZEN_OUT        <= (next_state == LPFC_FROZEN);
         INPUT_TIE_OUT     <= (next_state == LPFC_FROZEN);
         PLL_OFF_OUT       <= (next_state == LPFC_FROZEN);
         // self reset held high for the whole frozen state, released at exit
         SELF_RESET_OUT    <= (next_state == LPFC_FROZEN);
      end
   end

   // Previous synced core level, low after reset so no false loss
   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         core_prev <= 1'b0;
      end else begin
         core_prev <= core_sync[1];
      end
   end

   // context lost flag on a fall of the core supply
   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         CTX_LOST_OUT <= 1'b0;
      end else if (core_prev && !core_sync[1]) begin
         CTX_LOST_OUT <= 1'b1;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN || !supplies_ok || next_state == LPFC_FROZEN) begin
         out_cnt     <= 4'(OUT_LAG_CYC);
         IO_OE_N_OUT <= 1'b1;
      end else if (out_cnt != CNT_ZERO) begin
         out_cnt     <= out_cnt - CNT_ONE;
         IO_OE_N_OUT <= 1'b1;
      end else begin
         IO_OE_N_OUT <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   AST_TRISTATE_ON_LOSS: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      !supplies_ok |=> IO_OE_N_OUT)
      else $error("IO driven with a supply down");
   AST_OUT_LAG: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      $fell(FROZEN_OUT) |-> IO_OE_N_OUT[*5])
      else $error("Outputs enabled too early after exit");
   AST_PERMIT_NEEDS_PIN: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      FREEZE_PERMIT_OUT |-> $past(pin))
      else $error("Permit without freeze pin");
   AST_GATE_BEFORE_PERMIT: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      $rose(FREEZE_PERMIT_OUT) |-> !CLK_GATE_N_OUT && $past(!CLK_GATE_N_OUT))
      else $error("Permit raised before clock gated");
   AST_PERSIST: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      $rose(WAIT_HOUSE_OUT) |-> $past(pin, 3))
      else $error("Housekeeping without persistent pin");
   AST_PLL_BEFORE_RELEASE: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      $rose(CLK_GATE_N_OUT) |-> pll_sync[1])
      else $error("Gates released without PLL");
   AST_PLL_OFF_FROZEN: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      FROZEN_OUT |-> PLL_OFF_OUT && INPUT_TIE_OUT)
      else $error("PLL running while frozen");
   AST_EXIT_ON_PIN: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      (FROZEN_OUT && !pin) |=> !FREEZE_PERMIT_OUT)
      else $error("Permit held after pin dropped");

   COV_FREEZE: cover property (@(posedge CLOCK_IN) $rose(FROZEN_OUT));
   COV_EXIT: cover property (@(posedge CLOCK_IN) $fell(FROZEN_OUT));
   COV_ABORT: cover property (@(posedge CLOCK_IN) state == LPFC_CONFIRM && !pin);
endmodule

// File: lpfc_pkg.sv
package lpfc_pkg;
   // Clock rate and documented times
   localparam int CLK_PERIOD_NS    = 40;
   localparam int OUT_LAG_NS       = 200;
   localparam int OUT_LAG_CYC      = (OUT_LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PERSIST_CYC      = 4;
   localparam int PLL_LOCK_CYC     = 8;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE  = 4'h1;

   // Freeze variants
   typedef enum logic {
      LPFC_TYPE1 = 1'b0,
      LPFC_TYPE2 = 1'b1
   } lpfc_type_t;

   // Management state machine
   typedef enum logic [2:0] {
      LPFC_RUN     = 3'b000,
      LPFC_CONFIRM = 3'b001,
      LPFC_HOUSE   = 3'b010,
      LPFC_GATE    = 3'b011,
      LPFC_PERMIT  = 3'b100,
      LPFC_FROZEN  = 3'b101,
      LPFC_RELEASE = 3'b110
   } lpfc_state_t;

   // Supply status as one group
   typedef struct packed {
      logic core_ok;
      logic io_ok;
      logic prog_ok;
      logic test_ok;
   } lpfc_supply_t;
endpackage

// File: lpfc_host_model.sv
`timescale 1ns/1ps
module lpfc_host_model
   import lpfc_pkg::*;
#(
   parameter int LOCK_CYC = 6
)(
   input  wire logic clk_in,
   input  wire logic pll_off_in,
   output logic      pll_run_out,
   output logic      lock_ok_out
);
   int run_cnt  = LOCK_CYC;
   int lock_cnt = PLL_LOCK_CYC;

   // PLL restarts a while after it is switched back on
   always @(posedge clk_in) begin
      if (pll_off_in) begin
         run_cnt <= 0;
         lock_cnt <= 0;
      end else if (run_cnt < LOCK_CYC) begin
         run_cnt <= run_cnt + 1;
      end else if (lock_cnt < PLL_LOCK_CYC) begin
         lock_cnt <= lock_cnt + 1;
      end
   end
   assign pll_run_out = (run_cnt == LOCK_CYC);
   assign lock_ok_out = pll_run_out && (lock_cnt == PLL_LOCK_CYC);
endmodule

// File: low_power_freeze_control_test.sv
`timescale 1ns/1ps
module low_power_freeze_control_test;
   import lpfc_pkg::*;
   logic         clock = 1'b0;
   logic         rst   = 1'b1;
   logic         type2 = 1'b0;
   logic         done  = 1'b0;
   logic         pin   = 1'b0;
   lpfc_supply_t sup   = 4'hf;
   logic         pll_run, lock_ok, oe_n, tie, pll_off, gate_n;
   logic         wait_h, permit, frozen, lost, self_rst;
   int           failures    = 0;
   int           comparisons = 0;
   int           n;

   always #20 clock = ~clock;

   lpfc_freeze_ctrl lpfc_freeze_ctrl_inst (
      .CLOCK_IN(clock), .SYS_RST_IN(rst), .SUPPLY_IN(sup),
      .FREEZE_REQUEST_PIN_IN(pin), .TYPE2_IN(type2), .DONE_HOUSE_IN(done),
      .PLL_RUNNING_IN(pll_run), .IO_OE_N_OUT(oe_n), .INPUT_TIE_OUT(tie),
      .PLL_OFF_OUT(pll_off), .CLK_GATE_N_OUT(gate_n), .WAIT_HOUSE_OUT(wait_h),
      .FREEZE_PERMIT_OUT(permit), .FROZEN_OUT(frozen), .CTX_LOST_OUT(lost),
      .SELF_RESET_OUT(self_rst));
   lpfc_host_model lpfc_host_model_inst (
      .clk_in(clock), .pll_off_in(pll_off), .pll_run_out(pll_run), .lock_ok_out(lock_ok));

   // One comparison
   task check(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         failures++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask

   task cyc(input int k);
      repeat (k) @(negedge clock);
   endtask

   // Supply gating of user IO drive and context loss
   task test_power;
      cyc(10);
      check(oe_n === 1'b0, "io not driven");
      sup = 4'hc;
      cyc(4);
      check(oe_n === 1'b0, "side supplies matter");
      sup = 4'hb;
      cyc(4);
      check(oe_n === 1'b1 && lost === 1'b0, "io supply drop");
      sup = 4'hf;
      cyc(10);
      check(oe_n === 1'b0, "io not redriven");
      // core supply removed, context loss flag expected
      sup = 4'h7;
      cyc(4);
      check(oe_n === 1'b1 && lost === 1'b1, "core drop");
      sup = 4'hf;
      rst = 1'b1;
      cyc(8);
      rst = 1'b0;
      cyc(10);
      check(lost === 1'b0 && oe_n === 1'b0, "after reset");
      $display("test power done");
   endtask

   // Pin-only freeze, entry and exit
   task test_type1;
      type2 = 1'b0;
      pin = 1'b1;
      for (n = 0; n < 40 && frozen !== 1'b1; n++) cyc(1);
      check(frozen === 1'b1 && wait_h === 1'b0, "type1 entry");
      check(pll_off === 1'b1 && tie === 1'b1 && gate_n === 1'b0, "tie off");
      check(oe_n === 1'b1 && self_rst === 1'b1 && permit === 1'b1, "frozen io");
      pin = 1'b0;
      for (n = 0; n < 20 && frozen !== 1'b0; n++) cyc(1);
      check(permit === 1'b0 && gate_n === 1'b0, "exit start");
      check(oe_n === 1'b1 && self_rst === 1'b0, "output lag");
      for (n = 0; n < 60 && gate_n !== 1'b1; n++) cyc(1);
      check(gate_n === 1'b1 && pll_run === 1'b1, "gate release");
      check(oe_n === 1'b0, "outputs back");
      for (n = 0; n < 40 && lock_ok !== 1'b1; n++) cyc(1);
      check(lock_ok === 1'b1, "pll lock wait");
      $display("test type1 done");
   endtask

   // Missing housekeeping done holds off entry
   task test_type2;
      type2 = 1'b1;
      pin = 1'b1;
      for (n = 0; n < 40 && wait_h !== 1'b1; n++) cyc(1);
      check(wait_h === 1'b1, "no housekeeping request");
      cyc(20);
      check(frozen === 1'b0 && gate_n === 1'b1, "entered without done");
      done = 1'b1;
      for (n = 0; n < 20 && frozen !== 1'b1; n++) cyc(1);
      check(frozen === 1'b1 && permit === 1'b1, "type2 entry");
      done = 1'b0;
      pin = 1'b0;
      for (n = 0; n < 80 && gate_n !== 1'b1; n++) cyc(1);
      check(frozen === 1'b0 && gate_n === 1'b1, "type2 exit");
      $display("test type2 done");
   endtask

   // Short pin pulse and abort during housekeeping
   task test_abort;
      type2 = 1'b0;
      pin = 1'b1;
      cyc(2);
      pin = 1'b0;
      cyc(12);
      check(gate_n === 1'b1 && frozen === 1'b0, "pulse accepted");
      type2 = 1'b1;
      pin = 1'b1;
      for (n = 0; n < 40 && wait_h !== 1'b1; n++) cyc(1);
      pin = 1'b0;
      cyc(6);
      check(wait_h === 1'b0 && frozen === 1'b0 && permit === 1'b0, "abort");
      for (n = 0; n < 80 && gate_n !== 1'b1; n++) cyc(1);
      check(gate_n === 1'b1, "abort release");
      $display("test abort done");
   endtask

   task results;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      cyc(8);
      rst = 1'b0;
      test_power();
      test_type1();
      test_type2();
      test_abort();
      results();
   end

   // Watchdog
   initial begin
      #200000;
      failures++;
      results();
   end
endmodule
